/* common/hpp_pkg.sv */
// Constants for the host-port page-select and status register bank.
package hpp_pkg;
  localparam int PIN_COUNT  = 5;
  localparam int LOW_WIDTH  = 7;
  localparam int PAGE_WIDTH = 8;
  localparam int FULL_WIDTH = PAGE_WIDTH + LOW_WIDTH;

  localparam logic [FULL_WIDTH-1:0] PIN_LEVEL_ADDR = 15'h0140;
  localparam logic [FULL_WIDTH-1:0] CONTROL_ADDR   = 15'h017E;
  localparam logic [FULL_WIDTH-1:0] WINDOW_ADDR    = 15'h017F;

  localparam int FREEZE_BIT = 7;
  localparam int STATUS_BIT = 0;

  localparam logic [7:0] RESET_VALUE  = 8'h00;
  localparam logic [7:0] LAST_PAGE    = 8'h0F;
  localparam logic [7:0] PIN_USED_MSK = 8'h1F;

  typedef logic [7:0] hpp_byte_t;
endpackage

/* verilog/hpp_page_status.sv */
// Host-port bank: pin level readback, write freeze with access status, page select.
`timescale 1ns/10ps
`default_nettype none
module hpp_page_status (
  input  wire logic                           sys_clk,
  input  wire logic                           rst_n,
  input  wire logic [hpp_pkg::PIN_COUNT-1:0]  generalPinLevel,
  input  wire logic [hpp_pkg::PIN_COUNT-1:0]  pinInputMode,
  input  wire logic                           accValid,
  input  wire logic                           accWrite,
  input  wire logic [hpp_pkg::LOW_WIDTH-1:0]  accAddr,
  input  wire hpp_pkg::hpp_byte_t             accWdata,
  output logic                                accDone,
  output hpp_pkg::hpp_byte_t                  accRdata,
  output logic                                accHit,
  output logic [hpp_pkg::FULL_WIDTH-1:0]      fullAddr,
  output hpp_pkg::hpp_byte_t                  pageSelect,
  output logic                                writeFreeze
);
  import hpp_pkg::*;

  // Timing seen by the host side of the bank:
  //   - A request is taken on the rising edge at which accValid is high.
  //   - accDone rises on that same taking edge, high for one cycle per request.
  //   - Read data is loaded on that same edge and holds until the next read.
  //   - A write lands on the taking edge, so the very next access already
  //     sees the new page, freeze or status value.
  // Back-to-back requests are allowed; nothing here needs a wait state.
  // The bank never sees the serial framing; the low seven address bits
  // arrive already assembled, one byte per request.

  // Reset release and synchroniser stages.
  logic [1:0]           rstSync;
  logic                 rstSyncN;
  logic [PIN_COUNT-1:0] pinS1;
  logic [PIN_COUNT-1:0] pinS2;
  logic [PIN_COUNT-1:0] pinS3;
  logic [PIN_COUNT-1:0] pinSettled;

  // Register state.
  logic [PIN_COUNT-1:0] pinLevel;
  logic                 accessFailed;

  // Address decode and access qualification.
  logic                 hitLevel;
  logic                 hitControl;
  logic                 hitWindow;
  logic                 writeStrobe;
  logic                 readStrobe;
  logic                 pageLegal;
  logic                 pageWriteOk;

  // Values computed for the next edge.
  logic                 next_failed;
  hpp_byte_t            next_rdata;
  hpp_byte_t            controlValue;
  hpp_byte_t            pinView;

  // The control and window registers answer from every page, so the host can
  // always leave a page; only the pin readback lives at one full address.
  function automatic logic lowMatch(input logic [FULL_WIDTH-1:0] a,
                                    input logic [LOW_WIDTH-1:0] low);
    lowMatch = (a[LOW_WIDTH-1:0] == low);
  endfunction

  // Page numbers above the last real page are reserved. The same test both
  // refuses the write and sets the status bit, so the two can never disagree.
  function automatic logic isLegalPage(input hpp_byte_t value);
    isLegalPage = (value <= LAST_PAGE);
  endfunction

  // Assertion acts at once, but release passes two flops, so every register
  // leaves reset on the same clean edge whatever the phase of the release.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rstSync <= 2'h0;
    end else begin
      rstSync <= {rstSync[0], 1'b1};
    end
  end
  assign rstSyncN = rstSync[1];

  // The bank decodes a full fifteen-bit address. Only the pin readback needs
  // the page to match; a host that had chosen a page by mistake could
  // otherwise never reach the window register again.
  assign fullAddr   = {pageSelect, accAddr};
  assign hitLevel   = (fullAddr == PIN_LEVEL_ADDR);
  assign hitControl = lowMatch(CONTROL_ADDR, accAddr);
  assign hitWindow  = lowMatch(WINDOW_ADDR, accAddr);
  assign accHit     = hitLevel | hitControl | hitWindow;

  // Every write and read-data load is qualified here, once, by the request strobe.
  assign writeStrobe = accValid && accWrite;
  assign readStrobe  = accValid && !accWrite;
  assign pageLegal   = isLegalPage(accWdata);
  assign pageWriteOk = writeStrobe && hitWindow && !writeFreeze && pageLegal;

  // Three flops per pin: the first may go metastable, and a level is only
  // taken once the second and third agree, so a slow or noisy edge counts
  // once. The cost is four cycles of latency on every pin change.
  always_ff @(posedge sys_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      pinS1 <= '0;
      pinS2 <= '0;
      pinS3 <= '0;
    end else begin
      pinS1 <= generalPinLevel;
      pinS2 <= pinS1;
      pinS3 <= pinS2;
    end
  end
  assign pinSettled = ~(pinS2 ^ pinS3);

  // A pin outside input or control mode holds its last readback level, so
  // its bit does not follow the pin while the pin drives an output.
  always_ff @(posedge sys_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      pinLevel <= RESET_VALUE[PIN_COUNT-1:0];
    end else begin
      for (int i = 0; i < PIN_COUNT; i++) begin
        if (pinInputMode[i] && pinSettled[i]) begin
          pinLevel[i] <= pinS3[i];
        end
      end
    end
  end

  // The freeze bit itself stays writable while set; were it frozen too, the
  // host could never lift the lock again short of a reset.
  always_ff @(posedge sys_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      writeFreeze <= RESET_VALUE[FREEZE_BIT];
    end else if (writeStrobe && hitControl) begin
      writeFreeze <= accWdata[FREEZE_BIT];
    end
  end

  // A reserved page number is refused rather than stored, so the window
  // never points past the sixteen real pages.
  always_ff @(posedge sys_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      pageSelect <= RESET_VALUE;
    end else if (pageWriteOk) begin
      pageSelect <= accWdata;
    end
  end

  // The status bit is recomputed by every taken access rather than set and
  // cleared, so no set can race a clear. A read of the control register
  // returns the status left by the access before it.
  // A write fails when it aims at the window while frozen or with a reserved
  // page number, or when it aims at the read-only pin readback.
  // Reads never fail.
  always_comb begin
    next_failed = 1'b0;
    if (accWrite && hitWindow) begin
      next_failed = writeFreeze || !pageLegal;
    end
    if (accWrite && hitLevel) begin
      next_failed = 1'b1;
    end
  end

  // Idle cycles leave the status alone; only a taken request may change it.
  always_ff @(posedge sys_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      accessFailed <= RESET_VALUE[STATUS_BIT];
    end else if (accValid) begin
      accessFailed <= next_failed;
    end
  end

  // Reserved bits of every register read as zero.
  assign pinView = hpp_byte_t'(pinLevel) & PIN_USED_MSK;

  // The control view carries the freeze in its top bit and the status in its
  // lowest bit, with zero between them. Unmapped addresses read as zero and
  // count as successful accesses.
  always_comb begin
    controlValue             = RESET_VALUE;
    controlValue[FREEZE_BIT] = writeFreeze;
    controlValue[STATUS_BIT] = accessFailed;
    next_rdata               = RESET_VALUE;
    if (hitLevel) begin
      next_rdata = pinView;
    end else if (hitControl) begin
      next_rdata = controlValue;
    end else if (hitWindow) begin
      next_rdata = pageSelect;
    end
  end

  // accDone is the request strobe one edge late, so the host never waits.
  always_ff @(posedge sys_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      accDone <= 1'b0;
    end else begin
      accDone <= accValid;
    end
  end

  // Read data is loaded only by reads and holds through writes, so a write
  // between two reads cannot disturb a value the host has not yet taken.
  always_ff @(posedge sys_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      accRdata <= RESET_VALUE;
    end else if (readStrobe) begin
      accRdata <= next_rdata;
    end
  end
endmodule
`default_nettype wire

/* test/hpp_props.sv */
// Port checker for the page and status bank.
`timescale 1ns/10ps
`default_nettype none
module hpp_props (
  input wire logic        sys_clk, rst_n, accValid, accWrite, accDone, writeFreeze,
  input wire logic [6:0]  accAddr,
  input wire logic [7:0]  accWdata, pageSelect,
  input wire logic [14:0] fullAddr
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence pgWr; accValid && accWrite && accAddr == 7'h7F; endsequence
  a_done_next: assert property (accValid |=> accDone) else $error("no done");
  a_freeze_hold: assert property (pgWr ##0 writeFreeze |=> $stable(pageSelect))
    else $error("frozen page moved");
  a_page_take: assert property (pgWr ##0 (!writeFreeze && accWdata <= 8'h0F)
    |=> pageSelect == $past(accWdata)) else $error("page not taken");
  a_page_range: assert property (pageSelect <= 8'h0F) else $error("bad page");
  a_addr_join: assert property (fullAddr == {pageSelect, accAddr}) else $error("addr");
  a_lock_bit: assert property (accValid && accWrite && accAddr == 7'h7E
    |=> writeFreeze == $past(accWdata[7])) else $error("lock bit");
  a_reset_zero: assert property ($rose(rst_n) |-> pageSelect == 8'h00 && !writeFreeze)
    else $error("reset value");
endmodule
`default_nettype wire

/* test/hpp_host.sv */
// Host model issuing single-byte accesses.
`timescale 1ns/10ps
`default_nettype none
module hpp_host (
  input wire logic       sys_clk, accDone,
  input wire logic [7:0] accRdata,
  output logic           accValid = 1'h0, accWrite = 1'h0,
  output logic [6:0]     accAddr = 7'h00,
  output logic [7:0]     accWdata = 8'h00
);
  logic [7:0] rdByte;
  // A missing done pulse leaves an unknown byte, so every read through rd fails its check.
  task automatic xfer(input logic w, input logic [6:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    {accValid, accWrite, accAddr, accWdata} <= {1'h1, w, a, d};
    @(posedge sys_clk);
    accValid <= 1'h0;
    @(posedge sys_clk);
    rdByte = accDone ? accRdata : 8'hXX;
  endtask
endmodule
`default_nettype wire

/* test/host_port_page_and_status_test.sv */
// Bench for the page and status bank.
`timescale 1ns/10ps
`default_nettype none
module host_port_page_and_status_test;
  logic        sys_clk = 1'h0, rst_n = 1'h0, accValid, accWrite, accDone, accHit, writeFreeze;
  logic [4:0]  generalPinLevel = 5'h15, pinInputMode = 5'h1F;
  logic [6:0]  accAddr;
  logic [7:0]  accWdata, accRdata, pageSelect;
  logic [14:0] fullAddr;
  int          errorCnt = 0, numChecks = 0;
  hpp_page_status dut (.*);
  hpp_host h (.*);
  initial forever #10 sys_clk = ~sys_clk;
  task automatic ck(input logic [14:0] g, e);
    numChecks++;
    if (g !== e) begin
      errorCnt++;
      $display("wrong value %0t: %h not %h", $time, g, e);
    end
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    h.xfer(1'h0, a, 8'h00);
    ck(h.rdByte, e);
  endtask
  task automatic stopTest;
    $display("checks %0d errors %0d", numChecks, errorCnt);
    if (errorCnt == 0 && numChecks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic tPages;
    // The last pass writes a reserved page, which must leave page 15 and flag failure.
    for (int p = 0; p < 17; p++) begin
      h.xfer(1'h1, 7'h7F, 8'(p));
      ck(fullAddr, {8'(p < 16 ? p : 15), 7'h7F});
      rd(7'h7E, 8'(p / 16));
    end
    $display("pages done");
  endtask
  task automatic tFreeze;
    h.xfer(1'h1, 7'h7E, 8'h80);
    h.xfer(1'h1, 7'h7F, 8'h05);
    rd(7'h7E, 8'h81);
    ck(writeFreeze, 1'h1);
    h.xfer(1'h1, 7'h7E, 8'h00);
    h.xfer(1'h1, 7'h7F, 8'h02);
    ck(pageSelect, 8'h02);
    ck(writeFreeze, 1'h0);
    $display("freeze done");
  endtask
  task automatic tPins;
    rd(7'h40, 8'h15);
    ck(accHit, 1'h1);
    pinInputMode <= 5'h00;
    generalPinLevel <= 5'h0A;
    h.xfer(1'h1, 7'h40, 8'hFF);
    rd(7'h7E, 8'h01);
    rd(7'h40, 8'h15);
    pinInputMode <= 5'h1F;
    repeat (5) @(posedge sys_clk);
    rd(7'h40, 8'h0A);
    rd(7'h10, 8'h00);
    ck(accHit, 1'h0);
    $display("pins done");
  endtask
  initial begin
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'h1;
    repeat (3) @(posedge sys_clk);
    rd(7'h7E, 8'h00);
    rd(7'h7F, 8'h00);
    $display("reset done");
    tPages;
    tFreeze;
    tPins;
    stopTest;
  end
  initial begin
    repeat (3000) @(posedge sys_clk);
    errorCnt++;
    stopTest;
  end
endmodule
bind hpp_page_status hpp_props pr (.*);
`default_nettype wire
